// ---- nfc_regs.svh ----
// Constants for the NAND host controller: command codes, address layout, timing counts.
// Assumes a 10 MHz system clock; included by the package and the strobe and host modules.
`ifndef NFC_REGS_SVH
`define NFC_REGS_SVH
// ==========================================================================
// Command codes
`define NFC_CMD_READ_A 8'h00
`define NFC_CMD_READ_B 8'h01
`define NFC_CMD_READ_C 8'h50
`define NFC_CMD_READ_ID 8'h90
`define NFC_CMD_RESET 8'hff
`define NFC_CMD_PROG_SETUP 8'h80
`define NFC_CMD_PROG_EXEC 8'h10
`define NFC_CMD_COPY_EXEC 8'h8a
`define NFC_CMD_LOCK 8'h2a
`define NFC_CMD_UNLOCK_A 8'h23
`define NFC_CMD_UNLOCK_B 8'h24
`define NFC_CMD_LOCK_TIGHT 8'h2c
`define NFC_CMD_LOCK_STATUS 8'h7a
`define NFC_CMD_ERASE_SETUP 8'h60
`define NFC_CMD_ERASE_CONF 8'hd0
`define NFC_CMD_STATUS 8'h70
// ==========================================================================
// Address cycle layout
`define NFC_COL_LSB 0
`define NFC_COL_MSB 7
`define NFC_ROWL_LSB 8
`define NFC_ROWL_MSB 15
`define NFC_ROWH_LSB 16
`define NFC_ROWH_MSB 23
`define NFC_ADDR_FULL 2'h3
`define NFC_ADDR_ROW 2'h2
`define NFC_PAGE_IN_BLK_W 5
// ==========================================================================
// Strobe timing, ns, and cycles at the 100 ns clock
`define NFC_CLK_NS 100
`define NFC_T_STROBE_LOW_NS 60
`define NFC_T_STROBE_HIGH_NS 20
`define NFC_STROBE_LOW_CYC ((`NFC_T_STROBE_LOW_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_STROBE_HIGH_CYC ((`NFC_T_STROBE_HIGH_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`endif

// ---- nfc_pkg.sv ----
// Types shared by the NAND host controller modules.
// Assumes nfc_regs.svh is on the include path.
package nfc_pkg;
  `include "nfc_regs.svh"
  // ========================================================================
  // Bus cycle kinds
  typedef enum logic [1:0] {
    NFC_CYC_CMD,
    NFC_CYC_ADDR,
    NFC_CYC_DWR,
    NFC_CYC_DRD
  } nfc_cyc_type;
  // Operations requested from the user side
  typedef enum logic [3:0] {
    NFC_OP_READ_A,
    NFC_OP_READ_B,
    NFC_OP_READ_C,
    NFC_OP_READ_ID,
    NFC_OP_RESET,
    NFC_OP_STATUS,
    NFC_OP_PROGRAM,
    NFC_OP_COPY,
    NFC_OP_ERASE,
    NFC_OP_LOCK,
    NFC_OP_UNLOCK,
    NFC_OP_LOCK_TIGHT,
    NFC_OP_LOCK_STATUS
  } nfc_op_type;
endpackage : nfc_pkg

// ---- nfc_cyc_if.sv ----
// Bus cycle request channel between sequencer and strobe engine.
// Assumes one clock domain shared by both modules.
`timescale 1ns/100ps
interface nfc_cyc_if;
  import nfc_pkg::*;
  logic valid;
  logic ready;
  nfc_cyc_type kind;
  logic [15:0] wdata;
  logic done;
  logic [15:0] rdata;
  modport seq (output valid, output kind, output wdata, input ready, input done, input rdata);
  modport eng (input valid, input kind, input wdata, output ready, output done, output rdata);
endinterface : nfc_cyc_if

// ---- nfc_strobe.sv ----
// Strobe engine: performs one command, address, data write or data read bus cycle.
// Assumes the flash pins are synchronous to clk_in; pulses are whole clock periods.
`timescale 1ns/100ps
`include "nfc_regs.svh"
module nfc_strobe
  import nfc_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Cycle channel
  nfc_cyc_if.eng cyc,
  // Flash pins
  output logic cmd_latch_out,
  output logic addr_latch_out,
  output logic write_strobe_n_out,
  output logic read_strobe_n_out,
  output logic [15:0] io_out,
  output logic io_oe_out,
  input wire logic [15:0] io_in
);
  // ========================================================================
  // Pulse sequencer
  typedef enum logic [1:0] {S_IDLE, S_LOW, S_HIGH} nfc_st_type;
  localparam int LOWC = `NFC_STROBE_LOW_CYC;
  localparam int HIGHC = `NFC_STROBE_HIGH_CYC;
  nfc_st_type st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  nfc_cyc_type kind_r, kind_nxt;
  logic [15:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic done_r, done_nxt;
  assign cyc.ready = (st_r == S_IDLE);
  assign cyc.done = done_r;
  assign cyc.rdata = rd_r;
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    kind_nxt = kind_r;
    wd_nxt = wd_r;
    rd_nxt = rd_r;
    done_nxt = 1'b0;
    unique case (st_r)
      S_IDLE: if (cyc.valid) begin
        st_nxt = S_LOW;
        kind_nxt = cyc.kind;
        wd_nxt = cyc.wdata;
        cnt_nxt = 4'(LOWC - 1);
      end
      S_LOW: if (cnt_r == 4'h0) begin
        // Rising strobe edge latches the value
        st_nxt = S_HIGH; // RL14
        cnt_nxt = 4'(HIGHC - 1);
        if (kind_r == NFC_CYC_DRD) begin
          rd_nxt = io_in;
        end
      end else begin
        cnt_nxt = cnt_r - 4'h1;
      end
      S_HIGH: if (cnt_r == 4'h0) begin
        st_nxt = S_IDLE;
        done_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r - 4'h1;
      end
      default: st_nxt = S_IDLE;
    endcase
  end
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st_r <= S_IDLE;
      cnt_r <= 4'h0;
      kind_r <= NFC_CYC_DWR;
      wd_r <= 16'h0000;
      rd_r <= 16'h0000;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      kind_r <= kind_nxt;
      wd_r <= wd_nxt;
      rd_r <= rd_nxt;
      done_r <= done_nxt;
    end
  end
  // Latch selects hold across the whole cycle so they bracket the edge
  wire busy = (st_r != S_IDLE);
  assign cmd_latch_out = busy && (kind_r == NFC_CYC_CMD); // RL15
  assign addr_latch_out = busy && (kind_r == NFC_CYC_ADDR); // RL15
  assign write_strobe_n_out = !((st_r == S_LOW) && (kind_r != NFC_CYC_DRD)); // RL14
  assign read_strobe_n_out = !((st_r == S_LOW) && (kind_r == NFC_CYC_DRD));
  assign io_oe_out = busy && (kind_r != NFC_CYC_DRD);
  assign io_out = wd_r;
  // ========================================================================
  // Checks
  property p_we_only_writes;
    @(posedge clk_in) disable iff (srst_in)
      !write_strobe_n_out |-> (kind_r != NFC_CYC_DRD) && io_oe_out;
  endproperty
  a_we_only_writes: assert property (p_we_only_writes) else $error("write strobe on read"); // RL14
  property p_one_latch;
    @(posedge clk_in) disable iff (srst_in) !(cmd_latch_out && addr_latch_out);
  endproperty
  a_one_latch: assert property (p_one_latch) else $error("both latch selects high"); // RL15
endmodule : nfc_strobe

// ---- nfc_host.sv ----
// NAND host controller top: turns user operations into command/address/data cycles.
// Assumes a flash device on the pins and synchronous pin inputs at 10 MHz.
// Functional notes
// RL1 - Read code 00h selects first half, 01h selects second half of page.
// RL2 - Device drops surplus address cycles; host never sends extras.
// RL3 - Full address is three cycles: column, low row, high row.
// RL4 - Page read and program send three address cycles after the command.
// RL5 - Erase sends only two row cycles between 60h and D0h.
// RL6 - Reset, ID, status and read commands are single cycle.
// RL7 - Program: 80h, address and data, then 10h.
// RL8 - Erase uses 60h then D0h; copy-back uses 00h then 8Ah.
// RL9 - Operation starts only after the second code is latched.
// RL10 - Lock 2Ah, unlock 23h then 24h, lock-tight 2Ch, status 7Ah.
// RL11 - While busy only reset and status read are issued.
// RL12 - Host never issues an undefined command code.
// RL13 - Second-half pointer is used only on byte-wide parts.
// RL14 - Values written with write strobe low, latched on its rise.
// RL15 - Command latch for commands, address latch for addresses, neither for data.
// RL16 - Reads and programs use whole pages, erase whole 32-page blocks, 2048 in all.
// RL17 - 65,536 pages of 528 bytes or 264 words, spare at top.
// RL18 - Word-wide data uses sixteen lines; commands stay on eight.
// RL19 - Upper eight lines held low in command and address cycles.
// RL20 - Each read strobe fall yields the next data word.
// RL21 - Ready/busy low during program, erase or page read.
// RL22 - Erase blocks hold 32 pages; low five row bits ignored.
// RL23 - A lone second-cycle code is never sent.
`timescale 1ns/100ps
`include "nfc_regs.svh"
module nfc_host
  import nfc_pkg::*;
#(
  parameter bit WIDE = 1'b0,
  parameter int LEN_W = 10
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Operation request
  input wire logic op_valid_in,
  output logic op_ready_out,
  input wire nfc_op_type op_in,
  input wire logic [7:0] col_in,
  input wire logic [15:0] row_in,
  input wire logic [LEN_W-1:0] len_in,
  // Data streams
  input wire logic [15:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [15:0] rd_data_out,
  output logic rd_valid_out,
  output logic op_done_out,
  output logic op_refused_out,
  // Flash pins
  output logic chip_enable_n_out,
  output logic cmd_latch_out,
  output logic addr_latch_out,
  output logic write_strobe_n_out,
  output logic read_strobe_n_out,
  output logic [15:0] io_out,
  output logic io_oe_out,
  input wire logic [15:0] io_in,
  input wire logic ready_busy_in
);
  // ========================================================================
  // Helpers
  function automatic logic busy_ok(input nfc_op_type op);
    busy_ok = (op == NFC_OP_RESET) || (op == NFC_OP_STATUS); // RL11
  endfunction : busy_ok
  function automatic logic [7:0] first_code(input nfc_op_type op);
    unique case (op)
      NFC_OP_READ_B: first_code = `NFC_CMD_READ_B; // RL1
      NFC_OP_READ_C: first_code = `NFC_CMD_READ_C;
      NFC_OP_READ_ID: first_code = `NFC_CMD_READ_ID; // RL6
      NFC_OP_RESET: first_code = `NFC_CMD_RESET;
      NFC_OP_STATUS: first_code = `NFC_CMD_STATUS;
      NFC_OP_PROGRAM: first_code = `NFC_CMD_PROG_SETUP; // RL7
      NFC_OP_ERASE: first_code = `NFC_CMD_ERASE_SETUP; // RL8
      NFC_OP_LOCK: first_code = `NFC_CMD_LOCK; // RL10
      NFC_OP_UNLOCK: first_code = `NFC_CMD_UNLOCK_A;
      NFC_OP_LOCK_TIGHT: first_code = `NFC_CMD_LOCK_TIGHT;
      NFC_OP_LOCK_STATUS: first_code = `NFC_CMD_LOCK_STATUS;
      default: first_code = `NFC_CMD_READ_A; // Read A and copy-back
    endcase
  endfunction : first_code
  function automatic logic [7:0] second_code(input nfc_op_type op);
    unique case (op)
      NFC_OP_PROGRAM: second_code = `NFC_CMD_PROG_EXEC;
      NFC_OP_COPY: second_code = `NFC_CMD_COPY_EXEC; // RL8
      NFC_OP_ERASE: second_code = `NFC_CMD_ERASE_CONF;
      default: second_code = `NFC_CMD_UNLOCK_B;
    endcase
  endfunction : second_code
  function automatic logic [1:0] addr_cycles(input nfc_op_type op);
    unique case (op)
      NFC_OP_READ_A, NFC_OP_READ_B, NFC_OP_READ_C, NFC_OP_PROGRAM, NFC_OP_COPY:
        addr_cycles = `NFC_ADDR_FULL; // RL4
      NFC_OP_ERASE, NFC_OP_UNLOCK, NFC_OP_LOCK_TIGHT, NFC_OP_LOCK:
        addr_cycles = `NFC_ADDR_ROW; // RL5
      NFC_OP_READ_ID: addr_cycles = 2'h1;
      default: addr_cycles = 2'h0;
    endcase
  endfunction : addr_cycles
  function automatic logic two_cycle(input nfc_op_type op);
    two_cycle = (op == NFC_OP_PROGRAM) || (op == NFC_OP_COPY) ||
                (op == NFC_OP_ERASE) || (op == NFC_OP_UNLOCK);
  endfunction : two_cycle
  // ========================================================================
  // Engine
  nfc_cyc_if cyc ();
  nfc_strobe u_strobe (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .cyc(cyc),
    .cmd_latch_out(cmd_latch_out),
    .addr_latch_out(addr_latch_out),
    .write_strobe_n_out(write_strobe_n_out),
    .read_strobe_n_out(read_strobe_n_out),
    .io_out(io_out),
    .io_oe_out(io_oe_out),
    .io_in(io_in)
  );
  // ========================================================================
  // Operation sequencer
  typedef enum logic [2:0] {Q_IDLE, Q_CMD1, Q_ADDR, Q_WAIT, Q_DATA, Q_CMD2, Q_FIN}
    nfc_q_type;
  nfc_q_type q_r, q_nxt;
  nfc_op_type op_r, op_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [1:0] ai_r, ai_nxt;
  logic [LEN_W-1:0] left_r, left_nxt;
  logic issued_r, issued_nxt;
  logic [15:0] rd_r, rd_nxt;
  logic rdv_r, rdv_nxt, done_r, done_nxt, ref_r, ref_nxt;
  logic [7:0] row_low;
  wire dev_busy = !ready_busy_in;
  wire is_read = (op_r == NFC_OP_READ_A) || (op_r == NFC_OP_READ_B) ||
                 (op_r == NFC_OP_READ_C) || (op_r == NFC_OP_READ_ID) ||
                 (op_r == NFC_OP_STATUS) || (op_r == NFC_OP_LOCK_STATUS);
  wire is_write = (op_r == NFC_OP_PROGRAM);
  // Erase drops page-in-block bits; page size and block count are device-side
  assign row_low = (op_r == NFC_OP_ERASE) ?
    {addr_r[`NFC_ROWL_MSB:`NFC_ROWL_LSB + `NFC_PAGE_IN_BLK_W],
     `NFC_PAGE_IN_BLK_W'(0)} : addr_r[`NFC_ROWL_MSB:`NFC_ROWL_LSB]; // RL22 RL16
  logic [7:0] addr_byte;
  always_comb begin
    addr_byte = 8'h00;
    if (addr_cycles(op_r) == `NFC_ADDR_ROW) begin
      addr_byte = (ai_r == 2'h0) ? row_low : addr_r[`NFC_ROWH_MSB:`NFC_ROWH_LSB]; // RL5
    end else begin
      unique case (ai_r)
        2'h0: addr_byte = addr_r[`NFC_COL_MSB:`NFC_COL_LSB]; // RL3
        2'h1: addr_byte = row_low;
        default: addr_byte = addr_r[`NFC_ROWH_MSB:`NFC_ROWH_LSB];
      endcase
    end
  end
  assign op_ready_out = (q_r == Q_IDLE);
  assign wr_ready_out = (q_r == Q_DATA) && is_write && !issued_r && cyc.ready;
  always_comb begin
    q_nxt = q_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    ai_nxt = ai_r;
    left_nxt = left_r;
    issued_nxt = issued_r;
    rd_nxt = rd_r;
    rdv_nxt = 1'b0;
    done_nxt = 1'b0;
    ref_nxt = 1'b0;
    cyc.valid = 1'b0;
    cyc.kind = NFC_CYC_CMD;
    cyc.wdata = 16'h0000;
    unique case (q_r)
      Q_IDLE: if (op_valid_in) begin
        if ((dev_busy && !busy_ok(op_in)) || (WIDE && op_in == NFC_OP_READ_B)) begin
          ref_nxt = 1'b1; // RL11 RL13 RL12
        end else begin
          q_nxt = Q_CMD1;
          op_nxt = op_in;
          addr_nxt = {row_in, col_in}; // RL17
          ai_nxt = 2'h0;
          left_nxt = len_in;
          issued_nxt = 1'b0;
        end
      end
      Q_CMD1, Q_CMD2: begin
        // Copy-back confirm must wait out the page load busy time
        cyc.valid = !issued_r && ((q_r == Q_CMD1) || !dev_busy); // RL11
        cyc.kind = NFC_CYC_CMD; // RL15
        // Upper lines held low for commands
        cyc.wdata = {8'h00, (q_r == Q_CMD1) ? first_code(op_r) : second_code(op_r)}; // RL19
        if (cyc.valid && cyc.ready) issued_nxt = 1'b1;
        if (cyc.done) begin
          issued_nxt = 1'b0;
          if (q_r == Q_CMD2) q_nxt = Q_WAIT; // RL9
          else if (addr_cycles(op_r) != 2'h0) q_nxt = Q_ADDR;
          else q_nxt = Q_WAIT;
        end
      end
      Q_ADDR: begin
        cyc.valid = !issued_r;
        cyc.kind = NFC_CYC_ADDR;
        cyc.wdata = {8'h00, addr_byte}; // RL19 RL3
        if (cyc.valid && cyc.ready) issued_nxt = 1'b1;
        if (cyc.done) begin
          issued_nxt = 1'b0;
          ai_nxt = ai_r + 2'h1;
          // Exactly the count needed, no surplus cycles
          if (ai_r + 2'h1 == addr_cycles(op_r)) begin // RL2 RL4
            if (is_write) q_nxt = Q_DATA;
            else if (two_cycle(op_r)) q_nxt = Q_CMD2; // RL23
            else q_nxt = Q_WAIT;
          end
        end
      end
      Q_WAIT: if (ready_busy_in) begin // RL21
        if (is_read && left_r != '0) q_nxt = Q_DATA;
        else q_nxt = Q_FIN;
      end
      Q_DATA: begin
        if (left_r == '0) begin
          q_nxt = is_write ? Q_CMD2 : Q_FIN; // RL7
        end else begin
          cyc.valid = !issued_r && (is_write ? wr_valid_in : 1'b1);
          cyc.kind = is_write ? NFC_CYC_DWR : NFC_CYC_DRD;
          // Byte parts only carry the low lane
          cyc.wdata = WIDE ? wr_data_in : {8'h00, wr_data_in[7:0]}; // RL18
          if (cyc.valid && cyc.ready) issued_nxt = 1'b1;
          if (cyc.done) begin
            issued_nxt = 1'b0;
            left_nxt = left_r - 1'b1;
            if (!is_write) begin
              rd_nxt = WIDE ? cyc.rdata : {8'h00, cyc.rdata[7:0]}; // RL20
              rdv_nxt = 1'b1;
            end
          end
        end
      end
      Q_FIN: begin
        done_nxt = 1'b1;
        q_nxt = Q_IDLE;
      end
      default: q_nxt = Q_IDLE;
    endcase
  end
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      q_r <= Q_IDLE;
      op_r <= NFC_OP_RESET;
      addr_r <= 24'h000000;
      ai_r <= 2'h0;
      left_r <= '0;
      issued_r <= 1'b0;
      rd_r <= 16'h0000;
      rdv_r <= 1'b0;
      done_r <= 1'b0;
      ref_r <= 1'b0;
    end else begin
      q_r <= q_nxt;
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      ai_r <= ai_nxt;
      left_r <= left_nxt;
      issued_r <= issued_nxt;
      rd_r <= rd_nxt;
      rdv_r <= rdv_nxt;
      done_r <= done_nxt;
      ref_r <= ref_nxt;
    end
  end
  assign rd_data_out = rd_r;
  assign rd_valid_out = rdv_r;
  assign op_done_out = done_r;
  assign op_refused_out = ref_r;
  assign chip_enable_n_out = (q_r == Q_IDLE); // RL14
  // ========================================================================
  // Checks
  sequence s_cmd_cycle;
    cmd_latch_out && !write_strobe_n_out;
  endsequence
  property p_busy_gate;
    @(posedge clk_in) disable iff (srst_in)
      (q_r == Q_IDLE && op_valid_in && dev_busy && !busy_ok(op_in)) |=> op_refused_out;
  endproperty
  a_busy_gate: assert property (p_busy_gate) else $error("busy command not refused"); // RL11
  property p_upper_low;
    @(posedge clk_in) disable iff (srst_in)
      (cmd_latch_out || addr_latch_out) |-> io_out[15:8] == 8'h00;
  endproperty
  a_upper_low: assert property (p_upper_low) else $error("upper lines not low"); // RL19
  property p_ce_low;
    @(posedge clk_in) disable iff (srst_in) !write_strobe_n_out |-> !chip_enable_n_out;
  endproperty
  a_ce_low: assert property (p_ce_low) else $error("strobe with chip disabled"); // RL14
  property p_addr_count;
    @(posedge clk_in) disable iff (srst_in) (q_r == Q_ADDR) |-> ai_r < addr_cycles(op_r);
  endproperty
  a_addr_count: assert property (p_addr_count) else $error("surplus address cycle"); // RL2
  property p_second_after_setup;
    @(posedge clk_in) disable iff (srst_in)
      (q_r == Q_CMD2) |-> two_cycle(op_r);
  endproperty
  a_second_after_setup: assert property (p_second_after_setup) else $error("lone second code"); // RL23
  property p_no_b_wide;
    @(posedge clk_in) disable iff (srst_in)
      s_cmd_cycle |-> !(WIDE && io_out[7:0] == `NFC_CMD_READ_B && q_r == Q_CMD1);
  endproperty
  a_no_b_wide: assert property (p_no_b_wide) else $error("01h on word part"); // RL13
  property p_erase_row;
    @(posedge clk_in) disable iff (srst_in)
      (q_r == Q_ADDR && op_r == NFC_OP_ERASE && addr_latch_out) |-> ai_r != 2'h2;
  endproperty
  a_erase_row: assert property (p_erase_row) else $error("erase third address"); // RL5
  property p_erase_page_bits;
    @(posedge clk_in) disable iff (srst_in)
      (addr_latch_out && op_r == NFC_OP_ERASE && ai_r == 2'h0) |->
        io_out[`NFC_PAGE_IN_BLK_W-1:0] == '0;
  endproperty
  a_erase_page_bits: assert property (p_erase_page_bits) else $error("page bits in erase"); // RL22
endmodule : nfc_host

// ---- nfc_flash_model.sv ----
// Behavioural flash device facing the host controller pins.
// Assumes strobes from nfc_host; clk_in only times the busy period.
`timescale 1ns/100ps
module nfc_flash_model
  import nfc_pkg::*;
(
  // Pins from host
  input wire logic clk_in,
  input wire logic chip_enable_n_in,
  input wire logic cmd_latch_in,
  input wire logic addr_latch_in,
  input wire logic write_strobe_n_in,
  input wire logic read_strobe_n_in,
  input wire logic [15:0] io_in,
  // Bench controls
  input wire logic force_busy_in,
  input wire logic [7:0] busy_len_in,
  // Device outputs
  output logic [15:0] io_out,
  output logic ready_busy_out
);
  logic [7:0] cmd_q[$];
  logic [7:0] addr_q[$];
  logic [15:0] data_q[$];
  int viol = 0;
  int busy_cnt = 0;
  int acnt = 0;
  logic [7:0] last_cmd = 8'hff;
  logic [9:0] col = 10'h000;
  logic [15:0] dout = 16'h0000;
  // ==========================================================================
  // Busy line and bus drive
  assign ready_busy_out = (busy_cnt == 0) && !force_busy_in;
  // Released bus shows the inverse, never a stale copy
  assign io_out = read_strobe_n_in ? ~dout : dout;
  always @(posedge clk_in) if (busy_cnt > 0) busy_cnt--;
  // ==========================================================================
  // Command and address capture
  task automatic take_cmd(input logic [7:0] c);
    if (!ready_busy_out && c != 8'hff && c != 8'h70) return;
    if ((c == 8'h10 && last_cmd == 8'h80) || (c == 8'hd0 && last_cmd == 8'h60) ||
        (c == 8'h8a && last_cmd == 8'h00)) busy_cnt = busy_len_in;
    cmd_q.push_back(c);
    last_cmd = c;
    acnt = 0;
  endtask : take_cmd
  task automatic take_addr(input logic [7:0] a);
    int need;
    need = (last_cmd == 8'h90) ? 1 : (last_cmd inside {8'h60, 8'h23, 8'h2a, 8'h2c}) ? 2 : 3;
    if (acnt >= need) return;
    addr_q.push_back(a);
    if (acnt == 0) col = (last_cmd == 8'h50) ? {6'h20, a[3:0]} : {1'b0, last_cmd == 8'h01, a};
    acnt++;
    if (acnt == 3 && (last_cmd inside {8'h00, 8'h01, 8'h50})) busy_cnt = busy_len_in;
  endtask : take_addr
  always @(posedge write_strobe_n_in) begin
    if (!chip_enable_n_in) begin
      if (cmd_latch_in && addr_latch_in) viol++;
      else if (cmd_latch_in) take_cmd(io_in[7:0]);
      else if (addr_latch_in) take_addr(io_in[7:0]);
      else data_q.push_back(io_in);
      if ((cmd_latch_in || addr_latch_in) && io_in[15:8] !== 8'h00) viol++;
    end
  end
  always @(negedge read_strobe_n_in) begin
    if (!chip_enable_n_in) begin
      dout = {8'h3c, col[7:0] ^ {col[9:8], 6'h15}};
      col++;
    end
  end
endmodule : nfc_flash_model

// ---- tb_nfc_host.sv ----
// Self-checking bench for nfc_host on a byte-wide flash model.
// Assumes nfc_flash_model stands on the pins.
`timescale 1ns/100ps
module tb_nfc_host;
  import nfc_pkg::*;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic op_valid_in = 1'b0;
  nfc_op_type op_in = NFC_OP_RESET;
  logic [7:0] col_in = 8'h00;
  logic [15:0] row_in = 16'h0000;
  logic [9:0] len_in = 10'h000;
  logic [15:0] wr_data_in = 16'h0000;
  logic wr_valid_in = 1'b0;
  logic force_busy = 1'b0;
  logic [7:0] busy_len = 8'h01;
  logic op_ready, wr_ready, rd_valid, op_done, op_refused, io_oe, rb;
  logic ce_n, cmd_l, addr_l, wstb_n, rstb_n;
  logic [15:0] rd_data, host_io, flash_io, io_bus;
  logic [15:0] rd_q[$];
  int err_total = 0;
  int n_compared = 0;
  int wr_idx = 0;
  logic wr_pend = 1'b0;
  // ==========================================================================
  // Design, device and shared bus
  assign io_bus = io_oe ? host_io : flash_io;
  nfc_host #(.WIDE(1'b0), .LEN_W(10)) u_dut (
    .clk_in(clk_in), .srst_in(srst_in), .op_valid_in(op_valid_in), .op_ready_out(op_ready),
    .op_in(op_in), .col_in(col_in), .row_in(row_in), .len_in(len_in), .wr_data_in(wr_data_in),
    .wr_valid_in(wr_valid_in), .wr_ready_out(wr_ready), .rd_data_out(rd_data),
    .rd_valid_out(rd_valid), .op_done_out(op_done), .op_refused_out(op_refused),
    .chip_enable_n_out(ce_n), .cmd_latch_out(cmd_l), .addr_latch_out(addr_l),
    .write_strobe_n_out(wstb_n), .read_strobe_n_out(rstb_n), .io_out(host_io),
    .io_oe_out(io_oe), .io_in(io_bus), .ready_busy_in(rb));
  nfc_flash_model u_flash (
    .clk_in(clk_in), .chip_enable_n_in(ce_n), .cmd_latch_in(cmd_l), .addr_latch_in(addr_l),
    .write_strobe_n_in(wstb_n), .read_strobe_n_in(rstb_n), .io_in(io_bus),
    .force_busy_in(force_busy), .busy_len_in(busy_len), .io_out(flash_io), .ready_busy_out(rb));
  initial forever #50 clk_in = ~clk_in;
  // ==========================================================================
  // Data streams, judged at the falling edge where outputs are settled
  always @(negedge clk_in) begin
    if (rd_valid === 1'b1) rd_q.push_back(rd_data);
    if (!wr_valid_in) wr_idx = 0;
    else if (wr_pend) wr_idx++;
    wr_data_in <= 16'h00c0 + 16'(wr_idx);
    wr_pend = wr_valid_in && wr_ready;
  end
  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("Counts: %0d mismatches, %0d comparisons", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic do_op(input nfc_op_type op, input logic [7:0] col, input logic [15:0] row,
                       input logic [9:0] len, input logic refuse);
    int n;
    u_flash.cmd_q.delete();
    u_flash.addr_q.delete();
    u_flash.data_q.delete();
    rd_q.delete();
    @(negedge clk_in);
    op_in = op;
    col_in = col;
    row_in = row;
    len_in = len;
    op_valid_in = 1'b1;
    wr_valid_in = 1'b1;
    for (n = 0; op_ready !== 1'b1 && n < 50; n++) @(negedge clk_in);
    @(negedge clk_in);
    op_valid_in = 1'b0;
    for (n = 0; op_done !== 1'b1 && op_refused !== 1'b1 && n < 4000; n++) @(negedge clk_in);
    chk({15'h0, op_refused}, {15'h0, refuse});
    chk({15'h0, op_done | op_refused}, 16'h0001);
    chk({15'h0, rb | refuse}, 16'h0001);
    wr_valid_in = 1'b0;
    @(negedge clk_in);
  endtask : do_op
  task automatic log_chk(input int nc, input logic [15:0] codes, input int na,
                         input logic [23:0] ad);
    chk(16'(u_flash.cmd_q.size()), 16'(nc));
    chk({8'h00, u_flash.cmd_q[0]}, {8'h00, codes[15:8]});
    if (nc > 1) chk({8'h00, u_flash.cmd_q[1]}, {8'h00, codes[7:0]});
    if (na >= 0) chk(16'(u_flash.addr_q.size()), 16'(na));
    for (int i = 0; i < na; i++) chk({8'h00, u_flash.addr_q[i]}, {8'h00, ad[8*i +: 8]});
  endtask : log_chk
  // ==========================================================================
  // Scenarios
  task automatic sc_program();
    busy_len = 8'h28;
    do_op(NFC_OP_PROGRAM, 8'h12, 16'h3456, 10'd4, 1'b0);
    log_chk(2, 16'h8010, 3, 24'h345612);
    chk(16'(u_flash.data_q.size()), 16'h0004);
    for (int k = 0; k < 4; k++) chk({8'h00, u_flash.data_q[k][7:0]}, 16'h00c0 + 16'(k));
  endtask : sc_program
  task automatic sc_read();
    nfc_op_type ops[3] = '{NFC_OP_READ_A, NFC_OP_READ_B, NFC_OP_READ_C};
    logic [7:0] codes[3] = '{8'h00, 8'h01, 8'h50};
    logic [9:0] c;
    busy_len = 8'h28;
    for (int i = 0; i < 3; i++) begin
      do_op(ops[i], 8'h0e, 16'h0102, 10'd3, 1'b0);
      log_chk(1, {codes[i], 8'h00}, 3, 24'h01020e);
      chk(16'(rd_q.size()), 16'h0003);
      for (int k = 0; k < 3; k++) begin
        c = 10'(i * 256 + 14 + k);
        chk({8'h00, rd_q[k][7:0]}, {8'h00, c[7:0] ^ {c[9:8], 6'h15}});
      end
    end
  endtask : sc_read
  task automatic sc_erase();
    busy_len = 8'h28;
    do_op(NFC_OP_ERASE, 8'h77, 16'h345f, 10'd0, 1'b0);
    log_chk(2, 16'h60d0, 2, 24'h003440);
  endtask : sc_erase
  task automatic sc_table();
    nfc_op_type ops[8] = '{NFC_OP_COPY, NFC_OP_READ_ID, NFC_OP_RESET, NFC_OP_STATUS,
                           NFC_OP_LOCK, NFC_OP_UNLOCK, NFC_OP_LOCK_TIGHT, NFC_OP_LOCK_STATUS};
    logic [15:0] codes[8] = '{16'h008a, 16'h9000, 16'hff00, 16'h7000,
                              16'h2a00, 16'h2324, 16'h2c00, 16'h7a00};
    busy_len = 8'h28;
    for (int i = 0; i < 8; i++) begin
      do_op(ops[i], 8'h21, 16'h0043, 10'd1, 1'b0);
      log_chk((codes[i][7:0] != 8'h00) ? 2 : 1, codes[i], -1, 24'h0);
    end
  endtask : sc_table
  task automatic sc_busy();
    nfc_op_type ok_ops[2] = '{NFC_OP_STATUS, NFC_OP_RESET};
    logic [7:0] ok_codes[2] = '{8'h70, 8'hff};
    for (int i = 0; i < 2; i++) begin
      force_busy = 1'b1;
      do_op(NFC_OP_ERASE, 8'h00, 16'h0040, 10'd0, 1'b1);
      chk(16'(u_flash.cmd_q.size()), 16'h0000);
      fork
        begin
          repeat (30) @(negedge clk_in);
          force_busy = 1'b0;
        end
      join_none
      do_op(ok_ops[i], 8'h00, 16'h0000, 10'd1, 1'b0);
      chk({8'h00, u_flash.cmd_q[0]}, {8'h00, ok_codes[i]});
    end
  endtask : sc_busy
  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (3) @(negedge clk_in);
    srst_in = 1'b0;
    sc_program();
    sc_read();
    sc_erase();
    sc_table();
    sc_busy();
    chk(16'(u_flash.viol), 16'h0000);
    conclude();
  end
  initial begin
    repeat (60000) @(posedge clk_in);
    err_total++;
    conclude();
  end
endmodule : tb_nfc_host
